// ===== ees_buf_if.sv
// Port bundle between the link logic and the page buffer
`timescale 1ns/1ps
interface ees_buf_if;
    import ees_pkg::*;
    logic      wr_en;
    ees_off_t  wr_addr;
    ees_byte_t wr_data;
    ees_off_t  rd_addr;
    ees_byte_t rd_data;

    modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr,
                   input rd_data);
    modport mem   (input wr_en, input wr_addr, input wr_data, input rd_addr,
                   output rd_data);
endinterface : ees_buf_if

// ===== ees_defines.svh
// Constants for the serial EEPROM slave front end
`ifndef EES_DEFINES_SVH
`define EES_DEFINES_SVH
`define EES_TWC_US      5000
`define EES_CLK_KHZ     25000
`define EES_PAGE_BYTES  8'h80
`define EES_BIT_LAST    4'h8
`define EES_TX_LAST     4'h7
`define EES_TYPE_HI     7
`define EES_TYPE_LO     4
`define EES_CS_HI       3
`define EES_CS_LO       1
`define EES_RW_BIT      0
`define EES_PTR_SPLIT   8
`define EES_PAGE_LSB    7
`endif

// ===== ees_master.sv
// Two-wire bus master model that drives the slave under test
`timescale 1ns/1ps
module ees_master #(
    parameter int HALF = 10
) (
    // Clock
    input  wire logic       clk_i,
    // Bus
    input  wire logic       sda_i,
    output logic            scl_o,
    output logic            sda_low_o
);
    initial begin
        scl_o     = 1'b1; // Bus starts idle, both lines high
        sda_low_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // Also serves as a repeated Start after an acknowledge
    task automatic start_cond;
        sda_low_o <= 1'b0;
        tick(HALF);
        scl_o <= 1'b1;
        tick(HALF);
        sda_low_o <= 1'b1;
        tick(HALF);
        scl_o <= 1'b0;
        tick(HALF);
    endtask : start_cond

    task automatic stop_cond;
        sda_low_o <= 1'b1;
        tick(HALF);
        scl_o <= 1'b1;
        tick(HALF);
        sda_low_o <= 1'b0;
        tick(HALF);
    endtask : stop_cond

    // Data moves HALF/2 after the previous falling edge, clear of both clock edges
    task automatic bit_xfer(input logic b, output logic s);
        sda_low_o <= ~b;
        tick(HALF);
        scl_o <= 1'b1;
        tick(HALF / 2);
        s = sda_i;
        tick(HALF / 2);
        scl_o <= 1'b0;
        tick(HALF / 2);
    endtask : bit_xfer

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], s);
        end
        bit_xfer(1'b1, s); // Line released for the acknowledge
        ack = ~s;
    endtask : wr_byte

    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(~ack, s); // Acknowledge driven only when ack is set; clear it for the last byte
    endtask : rd_byte
endmodule : ees_master

// ===== ees_page_buf.sv
// Page buffer memory with registered read data
`timescale 1ns/1ps
module ees_page_buf #(
    parameter int DEPTH = 128
) (
    input  wire logic clk_i,
    ees_buf_if.mem    bus
);
    import ees_pkg::*;

    ees_byte_t mem [DEPTH];

    // No reset: contents are only meaningful once written
    always_ff @(posedge clk_i) begin
        if (bus.wr_en) begin
            mem[bus.wr_addr] <= bus.wr_data;
        end
        bus.rd_data <= mem[bus.rd_addr];
    end
endmodule : ees_page_buf

// ===== ees_pkg.sv
// Types shared by the serial EEPROM slave front end
package ees_pkg;
    typedef logic [15:0] ees_addr_t;
    typedef logic [7:0]  ees_byte_t;
    typedef logic [6:0]  ees_off_t;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} ees_state_e;
    typedef enum logic [1:0] {PH_CTRL, PH_ADDR_HI, PH_ADDR_LO, PH_DATA} ees_phase_e;
endpackage : ees_pkg

// ===== ees_slave.sv
// Two-wire EEPROM slave: link protocol, page buffer drain, write-cycle timer
`timescale 1ns/1ps
`include "ees_defines.svh"
module ees_slave #(
    parameter logic [3:0] DEV_TYPE   = 4'h5,  // Arbitrary device-type code
    parameter int         TWC_CYCLES = `EES_TWC_US * (`EES_CLK_KHZ / 1000)
) (
    // System clock and reset
    input  wire logic              MCLK_I,
    input  wire logic              ARST_N_I,
    // Link clock
    input  wire logic              LINK_CLK_I,
    // Two-wire bus pins
    input  wire logic              SCL_I,
    input  wire logic              SDA_I,
    output logic                   SDA_O,
    output logic                   SDA_OE_N_O,
    // Straps
    input  wire logic              CHIP_SELECT_PIN_0_I,
    input  wire logic              CHIP_SELECT_PIN_1_I,
    input  wire logic              CHIP_SELECT_PIN_2_I,
    input  wire logic              WP_I,
    // Array port, link clock domain
    output ees_pkg::ees_addr_t     ARR_RD_ADDR_O,
    input  wire ees_pkg::ees_byte_t ARR_RD_DATA_I,
    output logic                   ARR_WR_EN_O,
    output ees_pkg::ees_addr_t     ARR_WR_ADDR_O,
    output ees_pkg::ees_byte_t     ARR_WR_DATA_O,
    // Status, system clock domain
    output logic                   WR_CYCLE_O
);
    import ees_pkg::*;

    localparam int TW = $clog2(TWC_CYCLES + 1);

    ees_buf_if buf_bus ();

    ees_page_buf #(.DEPTH(128)) u_buf (
        .clk_i (LINK_CLK_I),
        .bus   (buf_bus.mem)
    );

    // Pin synchronisers, link domain
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic       p_scl;
    logic       p_sda;
    logic       busy_q1;
    logic       busy_s;

    always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sync1   <= 6'h3F;
            sync2   <= 6'h3F;
            p_scl   <= 1'b1;
            p_sda   <= 1'b1;
            busy_q1 <= 1'b0;
            busy_s  <= 1'b0;
        end else begin
            sync1   <= {WP_I, CHIP_SELECT_PIN_2_I, CHIP_SELECT_PIN_1_I,
                        CHIP_SELECT_PIN_0_I, SDA_I, SCL_I};
            sync2   <= sync1;
            p_scl   <= sync2[0];
            p_sda   <= sync2[1];
            busy_q1 <= WR_CYCLE_O;
            busy_s  <= busy_q1;
        end
    end

    logic       s_scl;
    logic       s_sda;
    logic [2:0] s_cs;
    logic       s_wp;
    assign s_scl = sync2[0];
    assign s_sda = sync2[1];
    assign s_cs  = sync2[4:2];
    assign s_wp  = sync2[5];

    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    assign scl_rise = s_scl & ~p_scl;
    assign scl_fall = ~s_scl & p_scl;
    assign start    = s_scl & p_scl & p_sda & ~s_sda;
    assign stop     = s_scl & p_scl & ~p_sda & s_sda;

    // Link protocol state
    ees_state_e state,   next_state;
    ees_phase_e phase,   next_phase;
    logic [3:0] bitcnt,  next_bitcnt;
    ees_byte_t  shreg,   next_shreg;
    ees_byte_t  txreg,   next_txreg;
    logic       rw,      next_rw;
    logic       more,    next_more;
    ees_addr_t  ptr,     next_ptr;
    logic [7:0] cnt,     next_cnt;
    ees_off_t   soff,    next_soff;
    logic       oe_n,    next_oe_n;
    logic       wr_cmd,  next_wr_cmd;
    logic       drain,   next_drain;
    logic [7:0] dcnt,    next_dcnt;
    logic       pend,    next_pend;
    logic       seen,    next_seen;
    logic       req,     next_req;
    logic       arr_we,  next_arr_we;
    ees_addr_t  arr_wa,  next_arr_wa;

    logic link_busy;
    logic match;
    logic commit;
    assign link_busy = drain | pend;
    assign match     = (shreg[`EES_TYPE_HI:`EES_TYPE_LO] == DEV_TYPE)
                     && (shreg[`EES_CS_HI:`EES_CS_LO] == s_cs)
                     && !link_busy;
    // Protect level taken at the Stop itself; later changes cannot matter
    assign commit    = wr_cmd && (cnt != 8'h00) && !s_wp && !link_busy;

    assign buf_bus.wr_addr = ptr[`EES_PAGE_LSB-1:0];
    assign buf_bus.wr_data = shreg;
    assign buf_bus.rd_addr = soff + dcnt[`EES_PAGE_LSB-1:0];

    always_comb begin
        next_state  = state;
        next_phase  = phase;
        next_bitcnt = bitcnt;
        next_shreg  = shreg;
        next_txreg  = txreg;
        next_rw     = rw;
        next_more   = more;
        next_ptr    = ptr;
        next_cnt    = cnt;
        next_soff   = soff;
        next_oe_n   = oe_n;
        next_wr_cmd = wr_cmd;
        next_req    = req;
        next_pend   = pend;
        next_seen   = seen;
        next_drain  = drain;
        next_dcnt   = dcnt;
        buf_bus.wr_en = 1'b0;
        if (start) begin
            next_state  = ST_RX;
            next_phase  = PH_CTRL;
            next_bitcnt = 4'h0;
            next_oe_n   = 1'b1;
            next_wr_cmd = 1'b0;
            next_cnt    = 8'h00;
        end else if (stop) begin
            next_state  = ST_IDLE;
            next_oe_n   = 1'b1;
            next_wr_cmd = 1'b0;
            if (commit) begin
                next_drain = 1'b1;
                next_dcnt  = 8'h00;
                next_pend  = 1'b1;
                next_seen  = 1'b0;
                next_req   = ~req;
            end
        end else begin
            case (state)
                ST_IDLE: begin
                    next_oe_n = 1'b1;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        next_shreg  = {shreg[6:0], s_sda};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == `EES_BIT_LAST) begin
                        next_state = ST_ACK;
                        next_oe_n  = 1'b0;
                        case (phase)
                            PH_CTRL: begin
                                next_rw    = shreg[`EES_RW_BIT];
                                next_phase = PH_ADDR_HI;
                                if (!match) begin
                                    next_state = ST_IDLE;
                                    next_oe_n  = 1'b1;
                                end
                            end
                            PH_ADDR_HI: begin
                                next_ptr   = {shreg, ptr[`EES_PTR_SPLIT-1:0]};
                                next_phase = PH_ADDR_LO;
                            end
                            PH_ADDR_LO: begin
                                next_ptr   = {ptr[15:`EES_PTR_SPLIT], shreg};
                                next_phase = PH_DATA;
                            end
                            default: begin
                                // Data byte is acked even when protected
                                buf_bus.wr_en = 1'b1;
                                next_wr_cmd   = 1'b1;
                                if (cnt == 8'h00) begin
                                    next_soff = ptr[`EES_PAGE_LSB-1:0];
                                end
                                if (cnt != `EES_PAGE_BYTES) begin
                                    next_cnt = cnt + 8'h01;
                                end
                                next_ptr = {ptr[15:`EES_PAGE_LSB],
                                            ptr[`EES_PAGE_LSB-1:0] + 7'h01};
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        next_bitcnt = 4'h0;
                        if (rw) begin
                            next_state = ST_TX;
                            next_txreg = ARR_RD_DATA_I;
                            next_oe_n  = ARR_RD_DATA_I[7];
                        end else begin
                            next_state = ST_RX;
                            next_oe_n  = 1'b1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == `EES_TX_LAST) begin
                            next_state = ST_RACK;
                            next_oe_n  = 1'b1;
                            next_ptr   = ptr + 16'h0001;
                        end else begin
                            next_txreg  = {txreg[6:0], 1'b0};
                            next_oe_n   = txreg[6];
                            next_bitcnt = bitcnt + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        next_more = !s_sda;
                    end else if (scl_fall) begin
                        if (more) begin
                            next_state  = ST_TX;
                            next_bitcnt = 4'h0;
                            next_txreg  = ARR_RD_DATA_I;
                            next_oe_n   = ARR_RD_DATA_I[7];
                        end else begin
                            next_state = ST_IDLE;
                            next_oe_n  = 1'b1;
                        end
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                    next_oe_n  = 1'b1;
                end
            endcase
        end
        // Copy the page into the array; far shorter than the write cycle
        next_arr_we = drain && (dcnt < cnt);
        next_arr_wa = {ptr[15:`EES_PAGE_LSB], buf_bus.rd_addr};
        if (drain) begin
            if (dcnt == cnt) begin
                next_drain = 1'b0;
            end else begin
                next_dcnt = dcnt + 8'h01;
            end
        end
        // Stay busy until the timer has been seen to start and finish
        if (pend) begin
            if (busy_s) begin
                next_seen = 1'b1;
            end else if (seen) begin
                next_pend = 1'b0;
            end
        end
    end

    always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state  <= ST_IDLE;
            phase  <= PH_CTRL;
            bitcnt <= 4'h0;
            shreg  <= 8'h00;
            txreg  <= 8'h00;
            rw     <= 1'b0;
            more   <= 1'b0;
            ptr    <= 16'h0000;
            cnt    <= 8'h00;
            soff   <= 7'h00;
            oe_n   <= 1'b1;
            wr_cmd <= 1'b0;
            drain  <= 1'b0;
            dcnt   <= 8'h00;
            pend   <= 1'b0;
            seen   <= 1'b0;
            req    <= 1'b0;
            arr_we <= 1'b0;
            arr_wa <= 16'h0000;
        end else begin
            state  <= next_state;
            phase  <= next_phase;
            bitcnt <= next_bitcnt;
            shreg  <= next_shreg;
            txreg  <= next_txreg;
            rw     <= next_rw;
            more   <= next_more;
            ptr    <= next_ptr;
            cnt    <= next_cnt;
            soff   <= next_soff;
            oe_n   <= next_oe_n;
            wr_cmd <= next_wr_cmd;
            drain  <= next_drain;
            dcnt   <= next_dcnt;
            pend   <= next_pend;
            seen   <= next_seen;
            req    <= next_req;
            arr_we <= next_arr_we;
            arr_wa <= next_arr_wa;
        end
    end

    assign SDA_O         = 1'b0;
    assign SDA_OE_N_O    = oe_n;
    assign ARR_RD_ADDR_O = ptr;
    assign ARR_WR_EN_O   = arr_we;
    assign ARR_WR_ADDR_O = arr_wa;
    assign ARR_WR_DATA_O = buf_bus.rd_data;

    // Write-cycle timer, system domain; request arrives as a toggle
    logic [2:0]    rq;
    logic          busy,  next_busy;
    logic [TW-1:0] tcnt,  next_tcnt;

    always_comb begin
        next_busy = busy;
        next_tcnt = tcnt;
        if (busy) begin
            if (tcnt == TW'(TWC_CYCLES - 1)) begin
                next_busy = 1'b0;
            end else begin
                next_tcnt = tcnt + TW'(1);
            end
        end else if (rq[1] ^ rq[2]) begin
            next_busy = 1'b1;
            next_tcnt = '0;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rq   <= 3'h0;
            busy <= 1'b0;
            tcnt <= '0;
        end else begin
            rq   <= {rq[1:0], req};
            busy <= next_busy;
            tcnt <= next_tcnt;
        end
    end

    assign WR_CYCLE_O = busy;

    // Checks
    a_start_ctrl: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        start |=> state == ST_RX && phase == PH_CTRL && bitcnt == 4'h0)
        else $error("start not taken");
    a_stop_idle: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        stop |=> state == ST_IDLE && oe_n)
        else $error("stop not taken");
    a_bit_count: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        state == ST_RX && scl_rise && !start && !stop |=> bitcnt == $past(bitcnt) + 4'h1)
        else $error("bit not counted");
    a_drive_low: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        $fell(oe_n) |-> !s_scl)
        else $error("drive began with clock high");
    a_busy_silent: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        state == ST_RX && phase == PH_CTRL && link_busy |=> oe_n)
        else $error("acked while busy");
    a_mismatch_idle: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        state == ST_RX && phase == PH_CTRL && scl_fall && bitcnt == `EES_BIT_LAST
        && !match && !start && !stop |=> state == ST_IDLE && oe_n)
        else $error("mismatch not ignored");
    a_wp_skip: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        stop && s_wp && !link_busy |=> !drain && req == $past(req))
        else $error("protected write committed");
    a_page_wrap: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        buf_bus.wr_en |=> ptr[15:7] == $past(ptr[15:7])
        && ptr[6:0] == $past(ptr[6:0]) + 7'h01)
        else $error("page pointer wrong");
    a_read_step: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        state == ST_TX && next_state == ST_RACK |=> ptr == $past(ptr) + 16'h0001)
        else $error("read pointer wrong");
    a_twc_limit: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
        busy |-> tcnt < TW'(TWC_CYCLES))
        else $error("write cycle overran");
    a_commit_busy: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        stop && commit |=> drain && pend)
        else $error("commit lost");

    c_write: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I) $rose(busy));
    c_read: cover property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        state == ST_RACK && scl_rise && !s_sda);
    c_mismatch: cover property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        state == ST_RX && phase == PH_CTRL && scl_fall && bitcnt == `EES_BIT_LAST && !match);
    c_protect: cover property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        stop && wr_cmd && s_wp);
endmodule : ees_slave

// ===== tb_ees_slave.sv
// Self-checking testbench for the two-wire EEPROM slave
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_ees_slave;
    import ees_pkg::*;
    localparam int TWC = 400;
    logic      mclk = 1'b0, link_clk = 1'b0, arst_n = 1'b0, wp = 1'b0;
    logic      scl, m_low, sda_line, sda_o, oe_n, wr_en, ack, wcyc;
    logic [2:0] cs = 3'b101; // Straps settled before any traffic
    ees_addr_t rd_addr, wr_addr, last_addr;
    ees_byte_t rd_data = 8'h00, wr_data, last_data, d;
    int        error_cnt = 0, n_tests = 0, wr_cnt = 0, wc_run = 0, wc_len = 0, n0;
    typedef struct { ees_byte_t ctrl; logic ack; } ees_row_s;
    ees_row_s rows[5] = '{'{8'h5A, 1'b1}, '{8'hDA, 1'b0}, '{8'h58, 1'b0}, '{8'h5C, 1'b0},
                      '{8'h4A, 1'b0}};

    always #20 mclk = ~mclk;
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end
    assign sda_line = (m_low || (oe_n === 1'b0 && sda_o === 1'b0)) ? 1'b0 : 1'b1;

    ees_slave #(.TWC_CYCLES(TWC)) ees_slave_i (
        .MCLK_I(mclk), .ARST_N_I(arst_n), .LINK_CLK_I(link_clk), .SCL_I(scl), .SDA_I(sda_line),
        .SDA_O(sda_o), .SDA_OE_N_O(oe_n), .CHIP_SELECT_PIN_0_I(cs[0]),
        .CHIP_SELECT_PIN_1_I(cs[1]), .CHIP_SELECT_PIN_2_I(cs[2]), .WP_I(wp),
        .ARR_RD_ADDR_O(rd_addr), .ARR_RD_DATA_I(rd_data), .ARR_WR_EN_O(wr_en),
        .ARR_WR_ADDR_O(wr_addr), .ARR_WR_DATA_O(wr_data), .WR_CYCLE_O(wcyc));
    ees_master ees_master_i (.clk_i(mclk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(m_low));

    // Array content is a pattern of the address, so no storage is needed
    function automatic ees_byte_t arr_f(input ees_addr_t a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction : arr_f

    always @(posedge link_clk) begin
        rd_data <= arr_f(rd_addr);
        if (wr_en === 1'b1) begin
            wr_cnt++;
            last_addr = wr_addr;
            last_data = wr_data;
        end
    end
    always @(posedge mclk) begin
        if (wcyc === 1'b1) wc_run++;
        else if (wc_run != 0) begin
            wc_len = wc_run;
            wc_run = 0;
        end
    end

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    task automatic send_cmd(input ees_byte_t b[$], input logic exp);
        logic a;
        foreach (b[i]) begin
            ees_master_i.wr_byte(b[i], a);
            `CHK(a, exp)
        end
    endtask : send_cmd

    task automatic wr_seq(input ees_addr_t a, input ees_byte_t dq[$]);
        ees_master_i.start_cond();
        send_cmd({8'h5A, a[15:8], a[7:0], dq}, 1'b1);
        ees_master_i.stop_cond();
    endtask : wr_seq

    task automatic rd_one(input ees_addr_t a);
        ees_master_i.start_cond();
        send_cmd({8'h5B}, 1'b1);
        ees_master_i.rd_byte(1'b0, d);
        `CHK(d, arr_f(a))
        ees_master_i.stop_cond();
    endtask : rd_one

    // Bounded wait for the internal write cycle to start and finish
    task automatic wait_cycle;
        int k = 0;
        while (wcyc !== 1'b1 && k < 300) begin
            @(posedge mclk);
            k++;
        end
        `CHK(wcyc, 1'b1)
        while (wcyc !== 1'b0 && k < 3000) begin
            @(posedge mclk);
            k++;
        end
        `CHK(wcyc, 1'b0)
        ees_master_i.tick(20);
    endtask : wait_cycle

    initial begin
        #1000000;
        error_cnt++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        ees_master_i.tick(10);
        foreach (rows[i]) begin
            ees_master_i.start_cond();
            ees_master_i.wr_byte(rows[i].ctrl, ack);
            `CHK(ack, rows[i].ack)
            ees_master_i.stop_cond();
            $display("Test control row %0d done", i);
        end
        n0 = wr_cnt;
        wr_seq(16'h1234, {8'hC3});
        ees_master_i.start_cond();
        ees_master_i.wr_byte(8'h5A, ack);
        `CHK(ack, 1'b0)
        ees_master_i.stop_cond();
        wait_cycle();
        `CHK(wr_cnt - n0, 1)
        `CHK(last_addr, 16'h1234)
        `CHK(last_data, 8'hC3)
        `CHK(wc_len, TWC)
        rd_one(16'h1235);
        $display("Test byte write done");
        ees_master_i.start_cond();
        send_cmd({8'h5A, 8'hFF, 8'hFF}, 1'b1);
        ees_master_i.start_cond();
        send_cmd({8'h5B}, 1'b1);
        ees_master_i.rd_byte(1'b1, d);
        `CHK(d, arr_f(16'hFFFF))
        ees_master_i.rd_byte(1'b0, d);
        `CHK(d, arr_f(16'h0000))
        ees_master_i.stop_cond();
        $display("Test read wrap done");
        n0 = wr_cnt;
        wr_seq(16'h007F, {8'h11, 8'h22});
        wp <= 1'b1; // Late protect must not cancel this write
        wait_cycle();
        `CHK(wr_cnt - n0, 2)
        `CHK(last_addr, 16'h0000)
        `CHK(last_data, 8'h22)
        $display("Test page wrap done");
        n0 = wr_cnt;
        wr_seq(16'h0100, {8'h55});
        ees_master_i.tick(40);
        `CHK(wcyc, 1'b0)
        rd_one(16'h0101);
        `CHK(wr_cnt - n0, 0)
        $display("Test write protect done");
        // Mid-run reset: outputs fall back to idle and the pointer to zero
        arst_n <= 1'b0;
        ees_master_i.tick(3);
        `CHK(oe_n, 1'b1)
        `CHK(wr_en, 1'b0)
        `CHK(wcyc, 1'b0)
        `CHK(rd_addr, 16'h0000)
        `CHK(wr_addr, 16'h0000)
        arst_n <= 1'b1;
        ees_master_i.tick(10);
        rd_one(16'h0000);
        $display("Test mid-run reset done");
        // A repeated Start before the Stop throws the received data away
        wp <= 1'b0;
        n0 = wr_cnt;
        ees_master_i.start_cond();
        send_cmd({8'h5A, 8'h02, 8'h00, 8'h77}, 1'b1);
        ees_master_i.start_cond();
        ees_master_i.stop_cond();
        ees_master_i.tick(40);
        `CHK(wcyc, 1'b0)
        `CHK(wr_cnt - n0, 0)
        $display("Test repeated start discard done");
        test_done();
    end
endmodule : tb_ees_slave
